// ==== include/per_defs.svh ====
/*
 Constants of the protection event recorder: timing, register offsets, field values, reset values.
 Assumes a 100 MHz system clock and one-word registers on a 32-bit bus.
*/
`ifndef PER_DEFS_SVH
`define PER_DEFS_SVH
// ----
// Timing
// ----
`define PER_CLK_NS      10
`define PER_TICK_NS     1000000
`define PER_TICK_CYC    (`PER_TICK_NS / `PER_CLK_NS)
`define PER_TICKS_SEC   1000
`define PER_DEMAND_MIN  15
`define PER_DEMAND_SEC  (`PER_DEMAND_MIN * 60)
`define PER_RECIP_SH    20
// ----
// Recording
// ----
`define PER_DEPTH       5
`define PER_PCT_FULL    7'h64
`define PER_PCT_CAP     7'h63
`define PER_PCT_STEP    17'h00064
`define PER_CNT_MAX     8'hFF
// ----
// Display addresses
// ----
`define PER_DSP_BLK     4'h0
`define PER_DSP_FIRST   4'h1
`define PER_DSP_LAST    4'h9
`define PER_DSP_COMM    4'hA
`define PER_DSP_DARK    4'hF
`define PER_SUB_COMM    3'h5
`define PER_TEST_LAST   3'h7
// ----
// Register byte offsets; stack window bounds in words
// ----
`define PER_REG_STATUS  12'h000
`define PER_REG_BUSADR  12'h004
`define PER_REG_RATE    12'h008
`define PER_REG_MON     12'h00C
`define PER_REG_KEY     12'h010
`define PER_REG_PWD     12'h014
`define PER_REG_BANK    12'h018
`define PER_REG_CBF     12'h01C
`define PER_REG_DEMAND  12'h020
`define PER_REG_PEAK    12'h024
`define PER_REG_CNT0    12'h030
`define PER_REG_CNT3    12'h03C
`define PER_STK_W0      10'h010
`define PER_STK_WEND    10'h050
// ----
// Reset values of settings
// ----
`define PER_PWD_RST     16'h0000
`define PER_CBF_RST     16'h00C8
`endif

// ==== include/per_pkg.sv ====
/*
 Types of the protection event recorder.
 Assumes nothing beyond the constants header.
*/
package per_pkg;
    typedef struct packed {
        logic start;
        logic operate;
    } per_stage_t;

    typedef struct packed {
        logic [9:0] il1;
        logic [9:0] il2;
        logic [9:0] il3;
        logic [9:0] i0;
    } per_meas_t;

    typedef enum logic [1:0] {
        PER_NORM = 2'b00,
        PER_TEST = 2'b01
    } per_mode_t;
endpackage

// ==== src/per_recorder.sv ====
/*
 Recording and display logic of a combined overcurrent and earth-fault protection module,
 with an AHB-Lite register slave.
 Assumes stage flags and currents come from logic on CLK_SYS_I; buttons and status pins are asynchronous.
*/
// Operation
// RQ1: OC event pushes phase currents, five deep.
// RQ2: EF event pushes neutral current, five deep.
// RQ3: Demand of highest phase over fifteen-minute periods.
// RQ4: Peak demand since relay reset.
// RQ5: Low-set OC start duration in percent.
// RQ6: High-set OC start duration in percent.
// RQ7: EF stage durations likewise.
// RQ8: New start restarts duration; five kept.
// RQ9: Operated stage reads 100 percent.
// RQ10: Start counters 0 to 255.
// RQ11: Display shows address and value.
// RQ12: Register zero shows blocking input.
// RQ13: Test mode drives one signal at a time.
// RQ14: Bus address; zero means unused.
// RQ15: Data rate 4800 or 9600 baud.
// RQ16: Monitor zero when link works, else scrolls.
// RQ17: Setting writes need the password first.
// RQ18: Main or second settings bank.
// RQ19: Breaker failure operate time setting.
// RQ20: Dark after last register; step restarts.
// RQ21: Reset plus program clears records.
// RQ22: Power loss clears records, keeps settings.
`timescale 1ns/1ps
`include "per_defs.svh"
module per_recorder
    import per_pkg::*;
#(
    parameter int TICK_CYC   = `PER_TICK_CYC,
    parameter int DEMAND_SEC = `PER_DEMAND_SEC
) (
    // Clock and reset
    input  wire logic             CLK_SYS_I,
    input  wire logic             RSTN_I,
    // AHB-Lite slave
    input  wire logic             HSEL_I,
    input  wire logic [31:0]      HADDR_I,
    input  wire logic [1:0]       HTRANS_I,
    input  wire logic             HWRITE_I,
    input  wire logic [2:0]       HSIZE_I,
    input  wire logic [31:0]      HWDATA_I,
    input  wire logic             HREADY_I,
    output logic      [31:0]      HRDATA_O,
    output logic                  HREADYOUT_O,
    output logic                  HRESP_O,
    // Protection stages and measurement
    input  wire per_stage_t [3:0] STAGE_I,
    input  wire logic [3:0][15:0] OP_TIME_I,
    input  wire per_meas_t        MEAS_I,
    // Front panel and status pins
    input  wire logic             BTN_STEP_I,
    input  wire logic             BTN_RESET_I,
    input  wire logic             BTN_PROG_I,
    input  wire logic             BLOCK_IN_I,
    input  wire logic             AUX_FAIL_I,
    input  wire logic             COMM_OK_I,
    // Display
    output logic      [3:0]       DISP_ADDR_O,
    output logic      [9:0]       DISP_VAL_O,
    output logic                  DISP_ON_O,
    // Settings and test
    output logic      [7:0]       BUS_ADDR_O,
    output logic                  BAUD_9600_O,
    output logic                  BANK_SEL_O,
    output logic      [15:0]      CBF_TIME_O,
    output logic      [7:0]       TEST_SIG_O
);
    localparam int RECIP = (1 << `PER_RECIP_SH) / DEMAND_SEC;

    // ----
    // Input synchronisers and edges
    // ----
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] sync3_r;
    logic       step_edge;
    logic       prog_edge;
    logic       rst_edge;
    logic       clear_rec;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
            sync3_r <= 6'h00;
        end else begin
            sync1_r <= {COMM_OK_I, AUX_FAIL_I, BLOCK_IN_I, BTN_PROG_I, BTN_RESET_I, BTN_STEP_I};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign step_edge = sync2_r[0] & ~sync3_r[0];
    assign rst_edge  = sync2_r[1] & ~sync3_r[1];
    assign prog_edge = sync2_r[2] & ~sync3_r[2];
    assign clear_rec = (sync2_r[1] & sync2_r[2]) | sync2_r[4]; // RQ21 RQ22

    // ----
    // Millisecond and second ticks
    // ----
    logic [31:0] tick_cnt_r;
    logic [15:0] ms_cnt_r;
    logic        tick;
    logic        sec_tick;

    assign tick     = (tick_cnt_r == 32'(TICK_CYC - 1));
    assign sec_tick = tick && (ms_cnt_r == 16'(`PER_TICKS_SEC - 1));

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tick_cnt_r <= 32'h0000_0000;
            ms_cnt_r   <= 16'h0000;
        end else begin
            tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
            if (sec_tick) begin
                ms_cnt_r <= 16'h0000;
            end else if (tick) begin
                ms_cnt_r <= ms_cnt_r + 16'h0001;
            end
        end
    end

    // ----
    // Stage events
    // ----
    logic [3:0] act;
    logic [3:0] act_d_r;
    logic [3:0] rise;
    logic       oc_evt;
    logic       ef_evt;

    always_comb begin
        for (int s = 0; s < 4; s++) begin
            act[s] = STAGE_I[s].start | STAGE_I[s].operate;
        end
    end

    assign rise   = act & ~act_d_r;
    assign oc_evt = rise[0] | rise[1];
    assign ef_evt = rise[2] | rise[3];

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            act_d_r <= 4'h0;
        end else begin
            act_d_r <= act;
        end
    end

    // ----
    // Start duration percentages
    // ----
    logic [15:0] acc_r [4];
    logic [6:0]  pct_r [4];
    logic [7:0]  cnt_r [4];

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int s = 0; s < 4; s++) begin
                acc_r[s] <= 16'h0000;
                pct_r[s] <= 7'h00;
            end
        end else begin
            for (int s = 0; s < 4; s++) begin
                if (rise[s]) begin
                    acc_r[s] <= 16'h0000; // RQ8
                    pct_r[s] <= STAGE_I[s].operate ? `PER_PCT_FULL : 7'h00;
                end else if (act[s] && STAGE_I[s].operate) begin
                    pct_r[s] <= `PER_PCT_FULL; // RQ9
                end else if (act[s] && tick && pct_r[s] < `PER_PCT_CAP) begin
                    if ({1'b0, acc_r[s]} + `PER_PCT_STEP >= {1'b0, OP_TIME_I[s]}) begin
                        acc_r[s] <= 16'({1'b0, acc_r[s]} + `PER_PCT_STEP - {1'b0, OP_TIME_I[s]}); // RQ5 RQ6 RQ7
                        pct_r[s] <= pct_r[s] + 7'h01;
                    end else begin
                        acc_r[s] <= 16'({1'b0, acc_r[s]} + `PER_PCT_STEP);
                    end
                end
            end
        end
    end

    // Start counters saturate; a start in the clearing cycle still counts
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int s = 0; s < 4; s++) begin
                cnt_r[s] <= 8'h00;
            end
        end else begin
            for (int s = 0; s < 4; s++) begin
                if (rise[s] && (clear_rec || cnt_r[s] != `PER_CNT_MAX)) begin
                    cnt_r[s] <= (clear_rec ? 8'h00 : cnt_r[s]) + 8'h01; // RQ10
                end else if (clear_rec) begin
                    cnt_r[s] <= 8'h00;
                end
            end
        end
    end

    // ----
    // Record stacks: 0-2 phases, 3 neutral, 4-7 durations
    // ----
    logic [9:0] stk_r [8][`PER_DEPTH];
    logic [7:0] push;
    logic [7:0] top_wr;
    logic [9:0] din [8];

    always_comb begin
        push[2:0]   = {3{oc_evt}}; // RQ1
        push[3]     = ef_evt; // RQ2
        push[7:4]   = rise;
        top_wr[3:0] = 4'h0;
        top_wr[7:4] = act & ~rise;
        din[0]      = MEAS_I.il1;
        din[1]      = MEAS_I.il2;
        din[2]      = MEAS_I.il3;
        din[3]      = MEAS_I.i0;
        for (int s = 0; s < 4; s++) begin
            din[4 + s] = rise[s] ? 10'h000 : {3'h0, pct_r[s]};
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int k = 0; k < 8; k++) begin
                for (int e = 0; e < `PER_DEPTH; e++) begin
                    stk_r[k][e] <= 10'h000;
                end
            end
        end else begin
            for (int k = 0; k < 8; k++) begin
                if (clear_rec) begin
                    for (int e = 0; e < `PER_DEPTH; e++) begin
                        stk_r[k][e] <= 10'h000; // RQ21 RQ22
                    end
                end else if (push[k]) begin
                    for (int e = 1; e < `PER_DEPTH; e++) begin
                        stk_r[k][e] <= stk_r[k][e - 1]; // RQ1 RQ2 RQ8
                    end
                    stk_r[k][0] <= din[k];
                end else if (top_wr[k]) begin
                    stk_r[k][0] <= din[k];
                end
            end
        end
    end

    // ----
    // Maximum demand
    // ----
    logic [9:0]  ph_max;
    logic [23:0] sum_r;
    logic [15:0] sec_cnt_r;
    logic [9:0]  demand_r;
    logic [9:0]  peak_r;
    logic [47:0] prod;

    always_comb begin
        ph_max = MEAS_I.il1;
        if (MEAS_I.il2 > ph_max) begin
            ph_max = MEAS_I.il2;
        end
        if (MEAS_I.il3 > ph_max) begin
            ph_max = MEAS_I.il3;
        end
    end

    assign prod = 48'(sum_r + {14'h0000, ph_max}) * 48'(RECIP);

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sum_r     <= 24'h000000;
            sec_cnt_r <= 16'h0000;
            demand_r  <= 10'h000;
            peak_r    <= 10'h000;
        end else begin
            if (sec_tick) begin
                if (sec_cnt_r == 16'(DEMAND_SEC - 1)) begin
                    demand_r  <= 10'(prod >> `PER_RECIP_SH); // RQ3
                    sum_r     <= 24'h000000;
                    sec_cnt_r <= 16'h0000;
                end else begin
                    sum_r     <= sum_r + {14'h0000, ph_max};
                    sec_cnt_r <= sec_cnt_r + 16'h0001;
                end
            end
            if (clear_rec) begin
                demand_r <= 10'h000;
                peak_r   <= 10'h000;
            end else if (demand_r > peak_r) begin
                peak_r <= demand_r; // RQ4
            end
        end
    end

    // ----
    // Bus monitor
    // ----
    logic [7:0] mon_r;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mon_r <= 8'h00;
        end else if (sync2_r[5]) begin
            mon_r <= 8'h00; // RQ16
        end else if (tick) begin
            mon_r <= mon_r + 8'h01; // RQ16
        end
    end

    // ----
    // Front panel menu and test mode
    // ----
    per_mode_t mode_r;
    logic [3:0] disp_r;
    logic [2:0] sub_r;
    logic [2:0] tidx_r;
    logic [2:0] sub_max;
    logic [3:0] disp_nxt;

    always_comb begin
        case (disp_r)
            4'h4, 4'h5, 4'h6, 4'h8, 4'h9: sub_max = 3'h1;
            `PER_DSP_COMM:               sub_max = `PER_SUB_COMM;
            default:                     sub_max = 3'h0;
        endcase
        case (disp_r)
            `PER_DSP_LAST: disp_nxt = `PER_DSP_BLK;
            `PER_DSP_BLK:  disp_nxt = `PER_DSP_COMM;
            `PER_DSP_COMM: disp_nxt = `PER_DSP_DARK;
            `PER_DSP_DARK: disp_nxt = `PER_DSP_FIRST; // RQ20
            default:       disp_nxt = disp_r + 4'h1;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_r <= PER_NORM;
            disp_r <= `PER_DSP_FIRST;
            sub_r  <= 3'h0;
            tidx_r <= 3'h0;
        end else begin
            case (mode_r)
                PER_TEST: begin
                    if (rst_edge) begin
                        mode_r <= PER_NORM;
                    end else if (step_edge) begin
                        tidx_r <= (tidx_r == `PER_TEST_LAST) ? 3'h0 : tidx_r + 3'h1; // RQ13
                    end
                end
                default: begin
                    if (step_edge) begin
                        disp_r <= disp_nxt; // RQ20
                        sub_r  <= 3'h0;
                    end else if (prog_edge && !sync2_r[1]) begin
                        if (disp_r == `PER_DSP_BLK) begin
                            mode_r <= PER_TEST; // RQ13
                            tidx_r <= 3'h0;
                        end else begin
                            sub_r <= (sub_r >= sub_max) ? 3'h0 : sub_r + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ----
    // Settings held over the bus
    // ----
    logic [7:0]  bus_addr_r;
    logic        rate_r;
    logic [15:0] pwd_r;
    logic        bank_r;
    logic [15:0] cbf_r;
    logic        unlock_r;
    logic        wr_pend_r;
    logic [11:0] wr_addr_r;
    logic        ap;

    assign ap = HSEL_I & HTRANS_I[1] & HREADY_I;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else begin
            wr_pend_r <= ap & HWRITE_I;
            if (ap) begin
                wr_addr_r <= HADDR_I[11:0];
            end
        end
    end

    // Settings survive auxiliary power loss: only the power-on reset touches them
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bus_addr_r <= 8'h00;
            rate_r     <= 1'b0;
            pwd_r      <= `PER_PWD_RST;
            bank_r     <= 1'b0;
            cbf_r      <= `PER_CBF_RST;
            unlock_r   <= 1'b0;
        end else if (wr_pend_r) begin
            if (wr_addr_r == `PER_REG_KEY) begin
                unlock_r <= (HWDATA_I[15:0] == pwd_r); // RQ17
            end else if (unlock_r) begin
                if (wr_addr_r == `PER_REG_BUSADR) begin
                    bus_addr_r <= HWDATA_I[7:0]; // RQ14 RQ22
                end else if (wr_addr_r == `PER_REG_RATE) begin
                    rate_r <= HWDATA_I[0]; // RQ15
                end else if (wr_addr_r == `PER_REG_PWD) begin
                    pwd_r <= HWDATA_I[15:0];
                end else if (wr_addr_r == `PER_REG_BANK) begin
                    bank_r <= HWDATA_I[0]; // RQ18
                end else if (wr_addr_r == `PER_REG_CBF) begin
                    cbf_r <= HWDATA_I[15:0]; // RQ19
                end
            end
        end
    end

    // ----
    // Register read multiplexer
    // ----
    logic [31:0] rd_val;
    logic [9:0]  rw;
    logic [3:0]  rs;

    assign rw = HADDR_I[11:2];
    assign rs = 4'(rw[6:3] - 4'h2);

    always_comb begin
        rd_val = 32'h0000_0000;
        if (HADDR_I[11:0] == `PER_REG_STATUS) begin
            rd_val = {21'h000000, tidx_r, 5'h00, unlock_r, mode_r == PER_TEST, sync2_r[3]};
        end else if (HADDR_I[11:0] == `PER_REG_BUSADR) begin
            rd_val = {24'h000000, bus_addr_r};
        end else if (HADDR_I[11:0] == `PER_REG_RATE) begin
            rd_val = {31'h00000000, rate_r};
        end else if (HADDR_I[11:0] == `PER_REG_MON) begin
            rd_val = {24'h000000, mon_r};
        end else if (HADDR_I[11:0] == `PER_REG_BANK) begin
            rd_val = {31'h00000000, bank_r};
        end else if (HADDR_I[11:0] == `PER_REG_CBF) begin
            rd_val = {16'h0000, cbf_r};
        end else if (HADDR_I[11:0] == `PER_REG_DEMAND) begin
            rd_val = {22'h000000, demand_r};
        end else if (HADDR_I[11:0] == `PER_REG_PEAK) begin
            rd_val = {22'h000000, peak_r};
        end else if (HADDR_I[11:0] >= `PER_REG_CNT0 && HADDR_I[11:0] <= `PER_REG_CNT3) begin
            rd_val = {24'h000000, cnt_r[rw[1:0]]};
        end else if (rw >= `PER_STK_W0 && rw < `PER_STK_WEND && rw[2:0] < 3'(`PER_DEPTH)) begin
            rd_val = {22'h000000, stk_r[rs[2:0]][rw[2:0]]};
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (ap && !HWRITE_I) begin
            HRDATA_O <= rd_val;
        end
    end

    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

    // ----
    // Display value
    // ----
    logic [9:0] dval;

    always_comb begin
        dval = 10'h000;
        case (disp_r)
            4'h1, 4'h2, 4'h3: dval = stk_r[3'(disp_r - 4'h1)][0]; // RQ1
            4'h4: dval = (sub_r == 3'h0) ? demand_r : peak_r; // RQ3 RQ4
            4'h5: dval = (sub_r == 3'h0) ? stk_r[4][0] : {2'h0, cnt_r[0]}; // RQ5 RQ10
            4'h6: dval = (sub_r == 3'h0) ? stk_r[5][0] : {2'h0, cnt_r[1]}; // RQ6 RQ10
            4'h7: dval = stk_r[3][0]; // RQ2
            4'h8: dval = (sub_r == 3'h0) ? stk_r[6][0] : {2'h0, cnt_r[2]}; // RQ7 RQ10
            4'h9: dval = (sub_r == 3'h0) ? stk_r[7][0] : {2'h0, cnt_r[3]}; // RQ7 RQ10
            `PER_DSP_BLK: dval = {9'h000, sync2_r[3]}; // RQ12
            `PER_DSP_COMM: begin
                case (sub_r)
                    3'h0:    dval = {2'h0, bus_addr_r}; // RQ14
                    3'h1:    dval = {9'h000, rate_r}; // RQ15
                    3'h2:    dval = {2'h0, mon_r}; // RQ16
                    3'h4:    dval = {9'h000, bank_r}; // RQ18
                    3'h5:    dval = cbf_r[9:0]; // RQ19
                    default: dval = 10'h000;
                endcase
            end
            default: dval = 10'h000;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            DISP_ADDR_O <= `PER_DSP_FIRST;
            DISP_VAL_O  <= 10'h000;
            DISP_ON_O   <= 1'b1;
            TEST_SIG_O  <= 8'h00;
        end else begin
            DISP_ADDR_O <= disp_r; // RQ11
            DISP_VAL_O  <= dval; // RQ11
            DISP_ON_O   <= (disp_r != `PER_DSP_DARK); // RQ20
            TEST_SIG_O  <= (mode_r == PER_TEST) ? 8'(8'h01 << tidx_r) : 8'h00; // RQ13
        end
    end

    assign BUS_ADDR_O  = bus_addr_r;
    assign BAUD_9600_O = rate_r;
    assign BANK_SEL_O  = bank_r;
    assign CBF_TIME_O  = cbf_r;
endmodule

// ==== verification/per_panel_model.sv ====
/* Front panel model: a request holds its buttons down for nine cycles.
   Assumes requests come from the bench on the rising edge. */
`timescale 1ns/1ps
module per_panel_model (
    // Bench side and buttons
    input  wire logic       clk_i,
    input  wire logic [2:0] req_i,
    output logic      [2:0] btn_o
);
    logic [3:0] hold_r = 4'h0;
    initial btn_o = 3'h0;
    // Buttons may be held together, released buttons read not pressed
    always @(posedge clk_i) begin
        if (req_i != 3'h0) begin
            btn_o <= req_i;
            hold_r <= 4'h8;
        end else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
        else btn_o <= 3'h0;
    end
endmodule

// ==== verification/per_recorder_asserts.sv ====
/* Checker of the recorder's ports: display sequence, test drive, settings writes.
   Assumes binding onto per_recorder. */
`timescale 1ns/1ps
`include "per_defs.svh"
module per_recorder_chk (
    // Watched ports
    input wire logic        CLK_SYS_I,
    input wire logic        RSTN_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic        HREADY_I,
    input wire logic [3:0]  DISP_ADDR_O,
    input wire logic        DISP_ON_O,
    input wire logic [7:0]  BUS_ADDR_O,
    input wire logic        BAUD_9600_O,
    input wire logic        BANK_SEL_O,
    input wire logic [7:0]  TEST_SIG_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);
    wire wr = HSEL_I && HTRANS_I[1] && HWRITE_I && HREADY_I;
    a_addr_legal: assert property (DISP_ADDR_O <= 4'hA || DISP_ADDR_O == 4'hF)
        else $error("display address out of sequence");
    a_dark_off: assert property (DISP_ON_O == (DISP_ADDR_O != 4'hF))
        else $error("display lit state wrong");
    a_dark_wrap: assert property (DISP_ADDR_O == 4'hF ##1 DISP_ADDR_O != 4'hF |-> DISP_ADDR_O == 4'h1)
        else $error("dark not followed by first register");
    a_zero_after_nine: assert property (DISP_ADDR_O == 4'h9 ##1 $changed(DISP_ADDR_O) |-> DISP_ADDR_O == 4'h0)
        else $error("register nine not followed by zero");
    a_test_single: assert property ($onehot0(TEST_SIG_O))
        else $error("more than one test signal");
    a_test_at_zero: assert property (TEST_SIG_O != 8'h00 |-> DISP_ADDR_O == 4'h0)
        else $error("test drive away from register zero");
    a_busadr_cause: assert property ($changed(BUS_ADDR_O) |-> $past(wr && HADDR_I[11:0] == `PER_REG_BUSADR, 2))
        else $error("bus address changed without write");
    a_rate_cause: assert property ($changed(BAUD_9600_O) |-> $past(wr && HADDR_I[11:0] == `PER_REG_RATE, 2))
        else $error("rate changed without write");
    a_bank_cause: assert property ($changed(BANK_SEL_O) |-> $past(wr && HADDR_I[11:0] == `PER_REG_BANK, 2))
        else $error("bank changed without write");
    c_key: cover property (wr && HADDR_I[11:0] == `PER_REG_KEY);
    c_test: cover property (TEST_SIG_O != 8'h00);
    c_dark: cover property (!DISP_ON_O);
endmodule
bind per_recorder per_recorder_chk u_chk (.CLK_SYS_I, .RSTN_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HREADY_I,
    .DISP_ADDR_O, .DISP_ON_O, .BUS_ADDR_O, .BAUD_9600_O, .BANK_SEL_O, .TEST_SIG_O);

// ==== verification/tb_per_recorder.sv ====
/* Testbench of the recorder: AHB-Lite register tasks, panel presses, stage events.
   Assumes TICK_CYC 10, DEMAND_SEC 4. */
`timescale 1ns/1ps
`include "per_defs.svh"
module tb_per_recorder
    import per_pkg::*;
;
    logic clk = 0, rstn = 0, hsel = 0, hw = 0, blk = 0, aux = 0, cok = 1;
    logic [1:0] ht = 0;
    logic [31:0] ha = 0, hwd = 0, r;
    logic [2:0] req = 0;
    per_stage_t [3:0] stg = '0;
    per_meas_t meas = '0;
    wire [31:0] hrd;
    wire hro, don, b96, bank;
    wire [2:0] btn;
    wire [3:0] da;
    wire [9:0] dv;
    wire [7:0] badr, tsig;
    int error_cnt = 0, samples_checked = 0, k, n;
    logic [11:0] ra [4] = '{`PER_REG_BUSADR, `PER_REG_RATE, `PER_REG_BANK, `PER_REG_CBF};
    logic [31:0] rv [4] = '{32'h5A, 32'h1, 32'h1, 32'h123};
    logic [3:0] ea [12] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h0, 4'hA, 4'hF, 4'h1};
    always #5 clk = ~clk;
    per_recorder #(.TICK_CYC(10), .DEMAND_SEC(4)) dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .HSEL_I(hsel),
        .HADDR_I(ha), .HTRANS_I(ht), .HWRITE_I(hw), .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(hro),
        .HRDATA_O(hrd), .HREADYOUT_O(hro), .HRESP_O(), .STAGE_I(stg), .OP_TIME_I({4{16'h0003}}),
        .MEAS_I(meas), .BTN_STEP_I(btn[0]), .BTN_RESET_I(btn[1]), .BTN_PROG_I(btn[2]), .BLOCK_IN_I(blk),
        .AUX_FAIL_I(aux), .COMM_OK_I(cok), .DISP_ADDR_O(da), .DISP_VAL_O(dv), .DISP_ON_O(don),
        .BUS_ADDR_O(badr), .BAUD_9600_O(b96), .BANK_SEL_O(bank), .CBF_TIME_O(), .TEST_SIG_O(tsig));
    per_panel_model panel (.clk_i(clk), .req_i(req), .btn_o(btn));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic give_verdict;
        if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rdy;
        n = 0;
        @(posedge clk);
        while (hro !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) begin
            error_cnt++;
            give_verdict;
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1; ht <= 2'b10; hw <= w; ha <= {20'h0, a};
        rdy;
        hsel <= 1'b0; ht <= 2'b00; hwd <= d;
        rdy;
        r = hrd;
        if (w) @(posedge clk);
    endtask
    task automatic press(input logic [2:0] b);
        req <= b;
        @(posedge clk);
        req <= 3'h0;
        repeat (14) @(posedge clk);
    endtask
    task automatic pulse(input int s);
        stg[s].start <= 1'b1;
        repeat (5) @(posedge clk);
        stg <= '0;
        repeat (5) @(posedge clk);
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(1, `PER_REG_BUSADR, 32'h5);
        bus(0, `PER_REG_BUSADR, 0); chk("locked write", 0, r);
        bus(1, `PER_REG_KEY, 0);
        for (k = 0; k < 4; k++) begin
            bus(1, ra[k], rv[k]);
            bus(0, ra[k], 0); chk("setting", rv[k], r);
        end
        for (k = 1; k <= 6; k++) begin
            meas.il1 <= 10'(k); meas.i0 <= 10'(k); stg[2].start <= 1'b1;
            pulse(0);
        end
        for (k = 0; k < 5; k++) begin
            bus(0, 12'h040 + 12'(4 * k), 0); chk("phase stack", 32'(6 - k), r);
            bus(0, 12'h0A0 + 12'(4 * k), 0); chk("neutral stack", 32'(6 - k), r);
        end
        stg[0] <= 2'b11;
        repeat (5) @(posedge clk);
        bus(0, 12'h0C0, 0); chk("operated pct", 32'h64, r);
        stg[0] <= 2'b00;
        bus(0, `PER_REG_CNT0, 0); chk("start count", 32'h7, r);
        press(3'b110);
        bus(0, `PER_REG_CNT0, 0); chk("cleared count", 0, r);
        pulse(1);
        aux <= 1'b1;
        repeat (8) @(posedge clk);
        aux <= 1'b0;
        repeat (8) @(posedge clk);
        bus(0, 12'h034, 0); chk("aux count", 0, r);
        bus(0, `PER_REG_BUSADR, 0); chk("kept address", 32'h5A, r);
        cok <= 1'b0;
        repeat (80) @(posedge clk);
        bus(0, `PER_REG_MON, 0); chk("monitor scroll", 1, 32'(r != 0));
        cok <= 1'b1;
        repeat (8) @(posedge clk);
        bus(0, `PER_REG_MON, 0); chk("monitor ok", 0, r);
        blk <= 1'b1;
        for (k = 0; k < 12; k++) begin
            press(3'b001);
            chk("display address", 32'(ea[k]), 32'(da));
            if (k == 8) begin
                chk("blocking digit", 1, 32'(dv[0]));
                press(3'b100); chk("test first", 32'h1, 32'(tsig));
                press(3'b001); chk("test second", 32'h2, 32'(tsig));
                press(3'b010); chk("test exit", 0, 32'(tsig));
            end
        end
        repeat (42000) @(posedge clk);
        bus(0, `PER_REG_DEMAND, 0); chk("demand", 6, r);
        bus(0, `PER_REG_PEAK, 0); chk("peak", 6, r);
        give_verdict;
    end
endmodule
